// [mahbp_dev.sv]
// Purpose: front-end end of the host bus with transmit clock generation
// Assumes: all pins asynchronous to clock; 2.88 MHz tick (half the 5.76 MHz master) derived by accumulator
// Notes:   register 3 is read-only status
// Function
// RULE_01 - direction high reads, low writes
// RULE_02 - selected only when low select 0, high 1
// RULE_03 - drive data while read enable low
// RULE_04 - write captured on enable rising edge
// RULE_05 - selects count only during active enable
// RULE_06 - two choice lines pick the register
// RULE_07 - strap held high in normal operation
// RULE_08 - toggling sync input locks transmit clocks
// RULE_09 - constant sync: free-run or follow receive
// RULE_10 - programmable external input routing choice
// RULE_11 - clocks derived from 5.76 MHz master
// RULE_12 - eight-bit bus for samples and control
// RULE_13 - clock outputs have half duty cycle
// RULE_14 - pulse add/drop at 600/800 Hz
// RULE_15 - data lines released unless selected read
// RULE_16 - reads never alter register state
`timescale 1ns/10ps
module mahbp_dev
  import mahbp_pkg::*;
#(
  parameter int CORR_N      = CORR_TICKS,
  parameter int CORR_FAST_N = CORR_FAST_TICKS,
  parameter int IDLE_N      = CORR_TICKS
) (
  input  wire logic clock,
  input  wire logic rst_n,
  mahbp_bus_if.dev  bus,
  output logic      rx_bit_clock,
  output logic      exi_to_attenuator,
  output logic      sync_active
);
  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [15:0] s_pins;
  logic        s_en_n, s_rw, s_sel_n, s_sel, s_sync, s_strap;
  logic [1:0]  s_choice;
  logic [7:0]  s_data;

  mahbp_sync2 #(.W(16)) u_sync (
    .clock (clock),
    .rst_n (rst_n),
    .d     ({bus.enable_n, bus.rw, bus.select_active_low, bus.select_active_high,
             bus.register_choice_lines, bus.host_data_lines, bus.tx_sync_clock_in,
             bus.clock_init_strap}),
    .q     (s_pins)
  );
  assign {s_en_n, s_rw, s_sel_n, s_sel, s_choice, s_data, s_sync, s_strap} = s_pins;

  // ---------------------------------------------------------------
  // bus slave
  // ---------------------------------------------------------------
  logic [7:0] ctrl_q, ctrl_d, bit_q, bit_d, conv_q, conv_d;
  logic [7:0] dout_q, dout_d, wdata_q, wdata_d, rmux, status;
  logic [1:0] wsel_q, wsel_d;
  logic       doe_n_q, doe_n_d, wr_pend_q, wr_pend_d;
  logic       selected, rd_cycle, wr_phase;

  assign selected = !s_sel_n && s_sel;                     // RULE_02
  assign rd_cycle = !s_en_n && selected && s_rw;           // RULE_01 RULE_05
  assign wr_phase = !s_en_n && selected && !s_rw;          // RULE_01 RULE_05

  always_comb begin
    unique case (s_choice)                                 // RULE_06
      REG_CTRL: rmux = ctrl_q;
      REG_BIT:  rmux = bit_q;
      REG_CONV: rmux = conv_q;
      REG_STAT: rmux = status;
    endcase
  end

  always_comb begin
    ctrl_d    = ctrl_q;
    bit_d     = bit_q;
    conv_d    = conv_q;
    wr_pend_d = 1'b0;
    wsel_d    = wsel_q;
    wdata_d   = wdata_q;
    // the last low-phase sample is the one written at the rising edge
    if (wr_phase) begin
      wr_pend_d = 1'b1;
      wsel_d    = s_choice;
      wdata_d   = s_data;
    end
    if (wr_pend_q && s_en_n) begin                         // RULE_04
      unique case (wsel_q)                                 // RULE_06
        REG_CTRL: ctrl_d = wdata_q;
        REG_BIT:  bit_d  = wdata_q;
        REG_CONV: conv_d = wdata_q;
        REG_STAT: ctrl_d = ctrl_q;
      endcase
    end
    dout_d  = rd_cycle ? rmux : 8'h00;                     // RULE_03 RULE_16
    doe_n_d = !rd_cycle;                                   // RULE_15
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ctrl_q    <= CTRL_RST;
      bit_q     <= BIT_RST;
      conv_q    <= CONV_RST;
      wr_pend_q <= 1'b0;
      wsel_q    <= 2'h0;
      wdata_q   <= 8'h00;
      dout_q    <= 8'h00;
      doe_n_q   <= 1'b1;
    end else begin
      ctrl_q    <= ctrl_d;
      bit_q     <= bit_d;
      conv_q    <= conv_d;
      wr_pend_q <= wr_pend_d;
      wsel_q    <= wsel_d;
      wdata_q   <= wdata_d;
      dout_q    <= dout_d;
      doe_n_q   <= doe_n_d;
    end
  end

  assign bus.dev_dout      = dout_q;                       // RULE_12
  assign bus.dev_doe_n     = doe_n_q;
  assign exi_to_attenuator = ctrl_q[CTRL_EXI_BIT];         // RULE_10

  // ---------------------------------------------------------------
  // master tick and phase correction
  // ---------------------------------------------------------------
  logic [17:0] acc_q, acc_d;
  logic [15:0] corr_q, corr_d, idle_q, idle_d;
  logic        tick_q, tick_d, sync_prev_q, act_q, act_d;
  logic        err_q, err_d, lead_q, lead_d, ref_rise, corr_hit, hold;
  logic [1:0]  tx_step;
  logic [2:0]  lvl, rise;

  // strap low keeps every divider and the baud counter in its initial state
  assign hold = !s_strap;                                  // RULE_07
  assign corr_hit = tick_q && (corr_q == (ctrl_q[CTRL_FAST_BIT] ?
                    16'(CORR_FAST_N - 1) : 16'(CORR_N - 1)));             // RULE_14
  assign ref_rise = act_q ? (s_sync && !sync_prev_q) :                      // RULE_08
                    (ctrl_q[CTRL_RXLOCK_BIT] && rise[2]);                   // RULE_09
  // no reference leaves err clear, so the loop free-runs unshifted
  assign tx_step = (corr_hit && err_q) ? (lead_q ? 2'd0 : 2'd2) : 2'd1;    // RULE_14

  always_comb begin
    acc_d  = acc_q + ACC_STEP;                             // RULE_11
    tick_d = 1'b0;
    if (acc_d >= ACC_WRAP) begin
      acc_d  = acc_d - ACC_WRAP;
      tick_d = 1'b1;
    end
    corr_d = corr_q;
    if (tick_q) corr_d = corr_hit ? 16'h0000 : corr_q + 16'h0001;
    idle_d = idle_q;
    act_d  = act_q;
    if (s_sync != sync_prev_q) begin                       // RULE_08
      idle_d = 16'h0000;
      act_d  = 1'b1;
    end else if (tick_q) begin
      if (idle_q == 16'(IDLE_N - 1)) act_d = 1'b0;         // RULE_09
      else idle_d = idle_q + 16'h0001;
    end
    err_d  = err_q && !corr_hit;
    lead_d = lead_q;
    // reference during high half means the bit clock runs ahead
    if (ref_rise) begin
      err_d  = 1'b1;
      lead_d = lvl[0];
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      acc_q       <= 18'h0_0000;
      tick_q      <= 1'b0;
      corr_q      <= 16'h0000;
      idle_q      <= 16'h0000;
      act_q       <= 1'b0;
      sync_prev_q <= 1'b0;
      err_q       <= 1'b0;
      lead_q      <= 1'b0;
    end else begin
      acc_q       <= acc_d;
      tick_q      <= tick_d;
      corr_q      <= corr_d;
      idle_q      <= idle_d;
      act_q       <= act_d;
      sync_prev_q <= s_sync;
      err_q       <= err_d;
      lead_q      <= lead_d;
    end
  end

  // ---------------------------------------------------------------
  // half-period dividers: tx bit, tx conversion, rx bit
  // ---------------------------------------------------------------
  logic [7:0] half_reg [3];
  logic [1:0] step     [3];
  assign half_reg[0] = bit_q;
  assign half_reg[1] = conv_q;
  assign half_reg[2] = bit_q;
  assign step[0]     = tx_step;
  assign step[1]     = tx_step;
  assign step[2]     = 2'd1;

  for (genvar k = 0; k < 3; k++) begin : g_div
    logic [11:0] cnt_q, cnt_d, lim;
    logic        lvl_q, lvl_d;
    assign lim = (half_reg[k] == 8'h00) ? (12'h001 << UNIT_SHIFT) :
                 (12'(half_reg[k]) << UNIT_SHIFT);
    always_comb begin
      logic [11:0] sum;
      sum   = cnt_q + 12'(step[k]);
      cnt_d = cnt_q;
      lvl_d = lvl_q;
      if (hold) begin
        cnt_d = 12'h000;
        lvl_d = 1'b0;
      end else if (tick_q) begin
        if (sum >= lim) begin                              // RULE_13
          cnt_d = sum - lim;
          lvl_d = !lvl_q;
        end else begin
          cnt_d = sum;
        end
      end
    end
    always_ff @(posedge clock) begin
      if (!rst_n) begin
        cnt_q <= 12'h000;
        lvl_q <= 1'b0;
      end else begin
        cnt_q <= cnt_d;
        lvl_q <= lvl_d;
      end
    end
    assign lvl[k]  = lvl_q;
    assign rise[k] = lvl_d && !lvl_q;
  end

  // ---------------------------------------------------------------
  // baud clock: toggles every n+1 bit-clock rising edges
  // ---------------------------------------------------------------
  logic [3:0] baud_cnt_q, baud_cnt_d;
  logic       baud_q, baud_d;

  always_comb begin
    baud_cnt_d = baud_cnt_q;
    baud_d     = baud_q;
    if (hold) begin
      baud_cnt_d = 4'h0;
      baud_d     = 1'b0;
    end else if (rise[0]) begin
      if (baud_cnt_q == ctrl_q[CTRL_BAUD_LSB +: CTRL_BAUD_W]) begin
        baud_cnt_d = 4'h0;
        baud_d     = !baud_q;                              // RULE_13
      end else begin
        baud_cnt_d = baud_cnt_q + 4'h1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      baud_cnt_q <= 4'h0;
      baud_q     <= 1'b0;
    end else begin
      baud_cnt_q <= baud_cnt_d;
      baud_q     <= baud_d;
    end
  end

  assign status                  = {4'h0, act_q, lvl[1], baud_q, lvl[0]};
  assign bus.tx_bit_clock        = lvl[0];
  assign bus.tx_conversion_clock = lvl[1];
  assign bus.tx_baud_clock       = baud_q;
  assign rx_bit_clock            = lvl[2];
  assign sync_active             = act_q;
endmodule

// [mahbp_pkg.sv]
// Purpose: shared constants and types of the front-end host port and its bus master
// Assumes: 200 MHz system clock on both ends
// Notes:   register 3 reads status; writes to it are ignored
package mahbp_pkg;
  // ---------------------------------------------------------------
  // bus shape
  // ---------------------------------------------------------------
  localparam int DATA_W   = 8;
  localparam int CHOICE_W = 2;
  localparam int NUM_REGS = 4;

  // ---------------------------------------------------------------
  // clocking
  // ---------------------------------------------------------------
  localparam int CLK_MHZ         = 200;
  localparam int CLK_KHZ         = CLK_MHZ * 1000;
  localparam int MASTER_KHZ      = 5760;
  localparam int TICK_KHZ        = MASTER_KHZ / 2;
  localparam int CORR_HZ         = 600;
  localparam int CORR_FAST_HZ    = 800;
  localparam int CORR_TICKS      = TICK_KHZ * 1000 / CORR_HZ;
  localparam int CORR_FAST_TICKS = TICK_KHZ * 1000 / CORR_FAST_HZ;
  localparam int UNIT_SHIFT      = 3;
  localparam logic [17:0] ACC_STEP = 18'(TICK_KHZ);
  localparam logic [17:0] ACC_WRAP = 18'(CLK_KHZ);

  // ---------------------------------------------------------------
  // register offsets, fields, reset values
  // ---------------------------------------------------------------
  localparam logic [1:0] REG_CTRL = 2'h0;
  localparam logic [1:0] REG_BIT  = 2'h1;
  localparam logic [1:0] REG_CONV = 2'h2;
  localparam logic [1:0] REG_STAT = 2'h3;
  localparam int CTRL_RXLOCK_BIT = 0;
  localparam int CTRL_EXI_BIT    = 1;
  localparam int CTRL_FAST_BIT   = 2;
  localparam int CTRL_BAUD_LSB   = 4;
  localparam int CTRL_BAUD_W     = 4;
  localparam logic [7:0] CTRL_RST = 8'h10;
  localparam logic [7:0] BIT_RST  = 8'h4b;
  localparam logic [7:0] CONV_RST = 8'h19;

  // ---------------------------------------------------------------
  // host strobe timing
  // ---------------------------------------------------------------
  localparam int SETUP_NS      = 20;
  localparam int STROBE_NS     = 60;
  localparam int HOLD_NS       = 20;
  localparam int SETUP_CYCLES  = (SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int STROBE_CYCLES = (STROBE_NS * CLK_MHZ + 999) / 1000;
  localparam int HOLD_CYCLES   = (HOLD_NS * CLK_MHZ + 999) / 1000;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0001,
    ST_SETUP  = 4'b0010,
    ST_STROBE = 4'b0100,
    ST_HOLD   = 4'b1000
  } mahbp_state_type;
endpackage

// [mahbp_bus_if.sv]
// Purpose: pins between the signal processor and the front-end
// Assumes: data lines pulled high when nobody drives
// Notes:   output enables are active low
`timescale 1ns/10ps
interface mahbp_bus_if;
  import mahbp_pkg::*;
  logic [DATA_W-1:0]   host_dout;
  logic                host_doe_n;
  logic [DATA_W-1:0]   dev_dout;
  logic                dev_doe_n;
  logic [DATA_W-1:0]   host_data_lines;
  logic                rw;
  logic                select_active_low;
  logic                select_active_high;
  logic [CHOICE_W-1:0] register_choice_lines;
  logic                enable_n;
  logic                clock_init_strap;
  logic                tx_sync_clock_in;
  logic                tx_bit_clock;
  logic                tx_baud_clock;
  logic                tx_conversion_clock;

  // wire level; a clash shows the device value
  assign host_data_lines = !dev_doe_n  ? dev_dout  :
                           !host_doe_n ? host_dout : 8'hff;

  modport dev (
    input  host_data_lines, rw, select_active_low, select_active_high,
    input  register_choice_lines, enable_n, clock_init_strap, tx_sync_clock_in,
    output dev_dout, dev_doe_n, tx_bit_clock, tx_baud_clock, tx_conversion_clock
  );
  modport host (
    input  host_data_lines, tx_bit_clock, tx_baud_clock, tx_conversion_clock,
    output host_dout, host_doe_n, rw, select_active_low, select_active_high,
    output register_choice_lines, enable_n, clock_init_strap, tx_sync_clock_in
  );
endinterface

// [mahbp_sync2.sv]
// Purpose: two-stage synchroniser for pin inputs
// Assumes: bits are independent levels
// Notes:   first stage feeds only the second
`timescale 1ns/10ps
module mahbp_sync2 #(
  parameter int W = 1
) (
  input  wire logic         clock,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule

// [mahbp_host.sv]
// Purpose: processor end driving the front-end host bus
// Assumes: one request at a time on the user side
// Notes:   strap driven high from reset; terminal clock passed to the sync pin
`timescale 1ns/10ps
module mahbp_host
  import mahbp_pkg::*;
(
  input  wire logic                clock,
  input  wire logic                rst_n,
  input  wire logic                req_valid,
  input  wire logic                req_write,
  input  wire logic [CHOICE_W-1:0] req_choice,
  input  wire logic [DATA_W-1:0]   req_wdata,
  input  wire logic                term_clock,
  output logic                     req_ready,
  output logic                     resp_valid,
  output logic      [DATA_W-1:0]   resp_rdata,
  output logic      [2:0]          tx_clocks_seen,
  mahbp_bus_if.host                bus
);
  logic [DATA_W-1:0] s_data;
  logic [10:0]       s_all;

  mahbp_sync2 #(.W(11)) u_sync (
    .clock (clock),
    .rst_n (rst_n),
    .d     ({bus.host_data_lines, bus.tx_baud_clock, bus.tx_conversion_clock,
             bus.tx_bit_clock}),
    .q     (s_all)
  );
  assign s_data         = s_all[10:3];
  assign tx_clocks_seen = s_all[2:0];

  // ---------------------------------------------------------------
  // strobe sequencer
  // ---------------------------------------------------------------
  mahbp_state_type   st_q, st_d;
  logic [7:0]        cnt_q, cnt_d;
  logic [DATA_W-1:0] dout_q, dout_d, rdata_q, rdata_d;
  logic [1:0]        choice_q, choice_d;
  logic              rw_q, rw_d, doe_n_q, doe_n_d, sel_q, sel_d, en_n_q, en_n_d;
  logic              ready_q, ready_d, done_q, done_d, tclk_q;

  always_comb begin
    st_d     = st_q;
    cnt_d    = cnt_q - 8'h01;
    dout_d   = dout_q;
    rdata_d  = rdata_q;
    choice_d = choice_q;
    rw_d     = rw_q;
    doe_n_d  = doe_n_q;
    sel_d    = sel_q;
    en_n_d   = en_n_q;
    ready_d  = 1'b0;
    done_d   = 1'b0;
    unique case (st_q)
      ST_IDLE: begin
        ready_d = 1'b1;
        cnt_d   = cnt_q;
        if (req_valid && ready_q) begin
          st_d     = ST_SETUP;
          ready_d  = 1'b0;
          cnt_d    = 8'(SETUP_CYCLES - 1);
          rw_d     = !req_write;                           // RULE_01
          choice_d = req_choice;                           // RULE_06
          dout_d   = req_wdata;
          doe_n_d  = !req_write;
          sel_d    = 1'b1;                                 // RULE_02
        end
      end
      ST_SETUP: begin
        if (cnt_q == 8'h00) begin
          st_d   = ST_STROBE;
          en_n_d = 1'b0;
          cnt_d  = 8'(STROBE_CYCLES - 1);
        end
      end
      ST_STROBE: begin
        // enable stays low until the sample is taken
        if (cnt_q == 8'h00) begin                          // RULE_03
          st_d   = ST_HOLD;
          en_n_d = 1'b1;                                   // RULE_04
          cnt_d  = 8'(HOLD_CYCLES - 1);
          if (rw_q) rdata_d = s_data;
        end
      end
      ST_HOLD: begin
        if (cnt_q == 8'h00) begin
          st_d    = ST_IDLE;
          sel_d   = 1'b0;
          doe_n_d = 1'b1;
          done_d  = 1'b1;
          cnt_d   = 8'h00;
        end
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st_q     <= ST_IDLE;
      cnt_q    <= 8'h00;
      dout_q   <= 8'h00;
      rdata_q  <= 8'h00;
      choice_q <= 2'h0;
      rw_q     <= 1'b1;
      doe_n_q  <= 1'b1;
      sel_q    <= 1'b0;
      en_n_q   <= 1'b1;
      ready_q  <= 1'b0;
      done_q   <= 1'b0;
      tclk_q   <= 1'b0;
    end else begin
      st_q     <= st_d;
      cnt_q    <= cnt_d;
      dout_q   <= dout_d;
      rdata_q  <= rdata_d;
      choice_q <= choice_d;
      rw_q     <= rw_d;
      doe_n_q  <= doe_n_d;
      sel_q    <= sel_d;
      en_n_q   <= en_n_d;
      ready_q  <= ready_d;
      done_q   <= done_d;
      tclk_q   <= term_clock;
    end
  end

  assign req_ready                 = ready_q;
  assign resp_valid                = done_q;
  assign resp_rdata                = rdata_q;
  assign bus.host_dout             = dout_q;               // RULE_12
  assign bus.host_doe_n            = doe_n_q;
  assign bus.rw                    = rw_q;
  assign bus.select_active_low     = !sel_q;
  assign bus.select_active_high    = sel_q;
  assign bus.register_choice_lines = choice_q;
  assign bus.enable_n              = en_n_q;
  assign bus.clock_init_strap      = 1'b1;                 // RULE_07
  assign bus.tx_sync_clock_in      = tclk_q;
endmodule

// [mahbp_chk.sv]
// Purpose: concurrent checks on the pins between processor end and front-end end
// Assumes: both ends on one clock, synchronous active-low reset
// Notes:   device pin latency of three clocks: two input synchroniser stages plus its output register
`timescale 1ns/10ps
module mahbp_chk
  import mahbp_pkg::*;
(
  input logic                clock,
  input logic                rst_n,
  input logic [DATA_W-1:0]   host_dout,
  input logic                host_doe_n,
  input logic                dev_doe_n,
  input logic                rw,
  input logic                select_active_low,
  input logic                select_active_high,
  input logic [CHOICE_W-1:0] register_choice_lines,
  input logic                enable_n,
  input logic                clock_init_strap,
  input logic                tx_bit_clock
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  logic sel;
  assign sel = !select_active_low && select_active_high;

  // ---------------------------------------------------------------
  // device side
  // ---------------------------------------------------------------
  a_drive_needs_sel: assert property (!dev_doe_n |-> $past(sel && rw, 3))
    else $error("device drove data without a selected read");
  a_drive_starts: assert property ($fell(enable_n) && sel && rw |-> ##[2:4] !dev_doe_n)
    else $error("device did not drive during read strobe");
  a_drive_ends: assert property ($rose(enable_n) |-> ##[1:4] dev_doe_n)
    else $error("device kept driving after strobe");
  a_no_clash: assert property (!(!dev_doe_n && !host_doe_n))
    else $error("both ends drive the data lines");

  // ---------------------------------------------------------------
  // processor side
  // ---------------------------------------------------------------
  a_write_hold: assert property ($rose(enable_n) && !rw |-> !host_doe_n && $stable(host_dout))
    else $error("write data not held at strobe rise");
  a_enable_sel: assert property (!enable_n |-> sel)
    else $error("strobe active without selection");
  a_strap_high: assert property (clock_init_strap)
    else $error("clock init strap not high");
  a_strobe_len: assert property ($fell(enable_n) |-> !enable_n [*4])
    else $error("strobe shorter than four clocks");
  a_strobe_gap: assert property ($rose(enable_n) |-> enable_n [*4])
    else $error("strobe gap shorter than four clocks");
  a_choice_hold: assert property (!enable_n && !$past(enable_n) |->
                                  $stable(register_choice_lines) && $stable(rw))
    else $error("choice or direction moved during strobe");

  c_read: cover property ($fell(enable_n) && sel && rw);
  c_write: cover property ($rose(enable_n) && sel && !rw);
  c_tx_clock: cover property ($rose(tx_bit_clock));
endmodule

// [tb.sv]
// Purpose: self-checking bench with both ends of the host bus facing each other
// Assumes: small loop counts so the sync idle timeout fits a short run
// Notes:   stimulus lands 1 ns after each rising edge
`timescale 1ns/10ps
module tb;
  import mahbp_pkg::*;
  logic                clock     = 1'b0;
  logic                rst_n     = 1'b0;
  logic                req_valid = 1'b0;
  logic                req_write = 1'b0;
  logic [CHOICE_W-1:0] req_choice = 2'h0;
  logic [DATA_W-1:0]   req_wdata = 8'h00;
  logic                term_clock = 1'b0;
  logic                req_ready;
  logic                resp_valid;
  logic [DATA_W-1:0]   resp_rdata;
  logic [2:0]          tx_clocks_seen;
  logic                rx_bit_clock;
  logic                exi_to_attenuator;
  logic                sync_active;
  logic [3:0]          clks;
  int                  num_errors = 0;
  int                  compares   = 0;

  always #2.5 clock = ~clock;

  assign clks = {rx_bit_clock, tx_clocks_seen};

  mahbp_bus_if bus_if ();
  mahbp_dev #(.CORR_N(8), .CORR_FAST_N(6), .IDLE_N(16)) u_mahbp_dev (
    .clock(clock), .rst_n(rst_n), .bus(bus_if), .rx_bit_clock(rx_bit_clock),
    .exi_to_attenuator(exi_to_attenuator), .sync_active(sync_active));
  mahbp_host u_mahbp_host (
    .clock(clock), .rst_n(rst_n), .req_valid(req_valid), .req_write(req_write),
    .req_choice(req_choice), .req_wdata(req_wdata), .term_clock(term_clock),
    .req_ready(req_ready), .resp_valid(resp_valid), .resp_rdata(resp_rdata),
    .tx_clocks_seen(tx_clocks_seen), .bus(bus_if));
  mahbp_chk u_mahbp_chk (
    .clock(clock), .rst_n(rst_n), .host_dout(bus_if.host_dout),
    .host_doe_n(bus_if.host_doe_n), .dev_doe_n(bus_if.dev_doe_n), .rw(bus_if.rw),
    .select_active_low(bus_if.select_active_low),
    .select_active_high(bus_if.select_active_high),
    .register_choice_lines(bus_if.register_choice_lines), .enable_n(bus_if.enable_n),
    .clock_init_strap(bus_if.clock_init_strap), .tx_bit_clock(bus_if.tx_bit_clock));

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // one request on the user side; waits for ready and for the response pulse
  task automatic xfer(input logic wr, input logic [1:0] ch, input logic [7:0] wd);
    int k;
    k = 0;
    while (req_ready !== 1'b1 && k < 50) begin step(1); k++; end
    req_valid  = 1'b1;
    req_write  = wr;
    req_choice = ch;
    req_wdata  = wd;
    step(1);
    req_valid = 1'b0;
    k = 0;
    while (resp_valid !== 1'b1 && k < 50) begin step(1); k++; end
    chk({7'h0, resp_valid}, 8'h01);
  endtask

  // cycles until clock b of {rx bit, tx baud, tx conv, tx bit} changes; bounded for a stuck one
  task automatic run_len(input int b, output int n);
    logic v;
    v = clks[b];
    n = 0;
    while (clks[b] === v && n < 5000) begin step(1); n++; end
  endtask

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    logic [7:0] rst_tbl [3];
    logic [7:0] wr_tbl [3];
    int         hi;
    int         lo;
    int         mult_tbl [4];
    int         half_exp;
    rst_tbl = '{CTRL_RST, BIT_RST, CONV_RST};
    wr_tbl  = '{8'h12, 8'h01, 8'h02};
    step(20);
    rst_n = 1'b1;
    for (int i = 0; i < 3; i++) begin
      xfer(1'b0, 2'(i), 8'h00);
      chk(resp_rdata, rst_tbl[i]);
    end
    $display("test reset values done");
    for (int i = 0; i < 3; i++) xfer(1'b1, 2'(i), wr_tbl[i]);
    for (int i = 0; i < 3; i++) begin
      xfer(1'b0, 2'(i), 8'h00);
      chk(resp_rdata, wr_tbl[i]);
    end
    chk({7'h0, exi_to_attenuator}, 8'h01);
    $display("test write readback done");
    xfer(1'b1, 2'h3, 8'h5a);
    xfer(1'b0, 2'h3, 8'h00);
    chk({resp_rdata[7:4], 4'h0}, 8'h00);
    xfer(1'b0, 2'h0, 8'h00);
    chk(resp_rdata, 8'h12);
    xfer(1'b1, 2'h0, 8'h10);
    chk({7'h0, exi_to_attenuator}, 8'h00);
    $display("test status and routing done");
    // half periods in bit-register units: bit 1, conv 2, baud (field 1 + 1) * 2, rx bit 1
    mult_tbl = '{1, 2, 4, 1};
    for (int b = 0; b < 4; b++) begin
      // first run is partial, so only the next two are measured
      run_len(b, hi);
      run_len(b, hi);
      run_len(b, lo);
      half_exp = (mult_tbl[b] << UNIT_SHIFT) * CLK_KHZ / TICK_KHZ;
      chk({7'h0, hi >= half_exp && hi <= half_exp + 1}, 8'h01);
      chk({7'h0, hi - lo <= 1 && lo - hi <= 1}, 8'h01);
    end
    $display("test clock outputs done");
    repeat (12) begin
      step(100);
      term_clock = ~term_clock;
    end
    step(20);
    chk({7'h0, sync_active}, 8'h01);
    step(1500);
    chk({7'h0, sync_active}, 8'h00);
    $display("test sync input done");
    close_out();
  end

  initial begin
    repeat (40000) @(posedge clock);
    num_errors++;
    close_out();
  end
endmodule
